//--- logic/aos_pkg.sv
// Constants, register map and types for the analog output scaler
// What this block does
// [RQ1] Output equals value times scale, plus offset
// [RQ2] Sign discard outputs magnitude of result
// [RQ3] Otherwise limit result to selected range span
// [RQ4] Range codes: bipolar, unipolar V, mA, 4-20mA
// [RQ5] Base channels two, three are bipolar
// [RQ6] Plus/minus 100 percent maps to full scale
// [RQ7] Saturate result to plus/minus 100 percent
// [RQ8] Unsupported range holds output at zero
// [RQ9] Unipolar channel clips negatives to zero
// [RQ10] Option channels: one per card, ranges 0/1
// [RQ11] Recompute all channels once per millisecond
// [RQ12] Written inputs saturate to permitted limits
// [RQ13] Signed hundredths fixed point, wide product
package aos_pkg;
   localparam int unsigned NCH          = 5;
   localparam int unsigned PCT_W        = 16;
   localparam int unsigned ADDR_W       = 6;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TICK_NS       = 1000000;
   localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
   // Percent in hundredths
   localparam logic signed [31:0] PCT_ONE   = 32'sd10000;
   localparam logic signed [31:0] PCT_MAXIN = 32'sd30000;
   localparam logic signed [31:0] PCT_ZERO  = 32'sd0;
   localparam logic signed [15:0] SCALE_RST = 16'sh2710;
   localparam logic signed [31:0] DAC_FS    = 32'sd32767;
   // Register map: address = channel * 8 + field
   localparam int unsigned CH_LSB       = 3;
   localparam logic [2:0]  F_VALUE      = 3'h0;
   localparam logic [2:0]  F_SCALE      = 3'h1;
   localparam logic [2:0]  F_OFFSET     = 3'h2;
   localparam logic [2:0]  F_CTRL       = 3'h3;
   localparam logic [2:0]  F_RESULT     = 3'h4;
   localparam int unsigned CTRL_SD_BIT  = 0;
   localparam int unsigned CTRL_RNG_LSB = 1;
   // Channel indices of the option slots
   localparam int unsigned CH_OPT0      = 3;

   typedef enum logic [1:0] {
      RNG_BIP10V = 2'h0,
      RNG_UNI10V = 2'h1,
      RNG_0_20MA = 2'h2,
      RNG_4_20MA = 2'h3
   } aos_rng_e;

   typedef struct packed {
      logic signed [15:0] value;
      logic signed [15:0] scale;
      logic signed [15:0] offset;
      logic               sign_discard;
      aos_rng_e           rng;
   } aos_chan_s;

   localparam aos_rng_e RNG_RST [NCH] = '{RNG_UNI10V, RNG_UNI10V, RNG_BIP10V, RNG_BIP10V, RNG_BIP10V};
endpackage

//--- logic/aos_top.sv
// Analog output scaler: five channels of scale, offset, clamp and range limit
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module aos_top
   import aos_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
)(
   input  wire logic                   CLK_SYS,
   input  wire logic                   RST_N,
   input  wire logic [ADDR_W-1:0]      REG_ADDR,
   input  wire logic [PCT_W-1:0]       REG_WDATA,
   input  wire logic                   REG_WR,
   input  wire logic                   REG_RD,
   output logic      [PCT_W-1:0]       REG_RDATA,
   input  wire logic [1:0]             OPT_FITTED,
   output logic      [NCH*PCT_W-1:0]   DAC_CODE,
   output logic                        DAC_LOAD
);

   aos_chan_s              cfg_ff    [NCH];
   logic signed [15:0]     result_ff [NCH];
   logic [31:0]            tick_cnt_ff;
   logic                   tick;
   logic [2:0]             wr_ch;
   logic [2:0]             rd_ch;
   logic [2:0]             wr_fld;
   logic [2:0]             rd_fld;

   // Clamp into [lo, hi]
   function automatic logic signed [31:0] sat(input logic signed [31:0] x,
                                              input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
      if (x > hi)
         return hi;
      else if (x < lo)
         return lo;
      else
         return x;
   endfunction

   function automatic logic signed [15:0] sat_in(input logic [15:0] w);
      return 16'(sat(32'(signed'(w)), -PCT_MAXIN, PCT_MAXIN)); // RQ12
   endfunction

   // Which ranges a channel can drive
   function automatic logic supported(input int unsigned ch, input aos_rng_e r, input logic [1:0] fitted);
      logic ok;
      ok = 1'b0;
      if (ch == 0)
         ok = (r == RNG_UNI10V); // RQ4
      else if (ch < CH_OPT0)
         ok = (r == RNG_BIP10V); // RQ5
      else
         ok = fitted[ch-CH_OPT0] && (r == RNG_BIP10V || r == RNG_UNI10V); // RQ10
      return ok;
   endfunction

   // Processed percent in hundredths, before conversion
   function automatic logic signed [15:0] process(input aos_chan_s c, input logic ok);
      logic signed [31:0] prod;
      logic signed [31:0] r;
      // 16x16 product cannot overflow 32 bits; divide before offset
      prod = c.value * c.scale; // RQ13
      r = prod / PCT_ONE + 32'(c.offset); // RQ1
      r = sat(r, -PCT_ONE, PCT_ONE); // RQ7
      if (c.sign_discard && r < PCT_ZERO)
         r = -r; // RQ2
      else if (!c.sign_discard && c.rng != RNG_BIP10V)
         r = sat(r, PCT_ZERO, PCT_ONE); // RQ3 RQ9
      if (!ok)
         r = PCT_ZERO; // RQ8
      return 16'(r);
   endfunction

   // Linear map of +/-100 percent to converter full scale
   function automatic logic [15:0] to_code(input logic signed [15:0] p);
      logic signed [31:0] t;
      t = 32'(p) * DAC_FS / PCT_ONE; // RQ6
      return t[15:0];
   endfunction

   assign wr_ch  = REG_ADDR[ADDR_W-1:CH_LSB];
   assign wr_fld = REG_ADDR[CH_LSB-1:0];
   assign rd_ch  = wr_ch;
   assign rd_fld = wr_fld;

   // Millisecond update tick
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         tick_cnt_ff <= '0;
      else if (tick)
         tick_cnt_ff <= '0;
      else
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
   end
   assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1)); // RQ11

   // Channel settings
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < NCH; i++) begin
            cfg_ff[i].value        <= '0;
            cfg_ff[i].scale        <= SCALE_RST;
            cfg_ff[i].offset       <= '0;
            cfg_ff[i].sign_discard <= 1'b0;
            cfg_ff[i].rng          <= RNG_RST[i];
         end
      end else if (REG_WR && wr_ch < 3'(NCH)) begin
         case (wr_fld)
            F_VALUE:  cfg_ff[wr_ch].value  <= sat_in(REG_WDATA); // RQ12
            F_SCALE:  cfg_ff[wr_ch].scale  <= sat_in(REG_WDATA); // RQ12
            F_OFFSET: cfg_ff[wr_ch].offset <= sat_in(REG_WDATA); // RQ12
            F_CTRL: begin
               cfg_ff[wr_ch].sign_discard <= REG_WDATA[CTRL_SD_BIT];
               cfg_ff[wr_ch].rng          <= aos_rng_e'(REG_WDATA[CTRL_RNG_LSB +: 2]);
            end
            default: ;
         endcase
      end
   end

   // All channels evaluated together on the tick; settings sampled then
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < NCH; i++)
            result_ff[i] <= '0;
         DAC_CODE <= '0;
      end else if (tick) begin
         for (int i = 0; i < NCH; i++) begin
            result_ff[i] <= process(cfg_ff[i], supported(i, cfg_ff[i].rng, OPT_FITTED)); // RQ11
            DAC_CODE[i*PCT_W +: PCT_W] <= to_code(process(cfg_ff[i], supported(i, cfg_ff[i].rng, OPT_FITTED)));
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         DAC_LOAD <= 1'b0;
      else
         DAC_LOAD <= tick;
   end

   // Read data valid the cycle after the strobe only
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         REG_RDATA <= '0;
      else if (!REG_RD || rd_ch >= 3'(NCH))
         REG_RDATA <= '0;
      else begin
         case (rd_fld)
            F_VALUE:  REG_RDATA <= cfg_ff[rd_ch].value;
            F_SCALE:  REG_RDATA <= cfg_ff[rd_ch].scale;
            F_OFFSET: REG_RDATA <= cfg_ff[rd_ch].offset;
            F_CTRL:   REG_RDATA <= {13'h0, cfg_ff[rd_ch].rng, cfg_ff[rd_ch].sign_discard};
            F_RESULT: REG_RDATA <= result_ff[rd_ch];
            default:  REG_RDATA <= '0;
         endcase
      end
   end

endmodule

//--- testbench/aos_dac_model.sv
// Converter model: latches the channel codes on each load pulse
`timescale 1ns/1ps
module aos_dac_model
   import aos_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 load,
   input  wire logic [NCH*PCT_W-1:0] code,
   output logic      [NCH*PCT_W-1:0] held_ff,
   output int                        loads_ff
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_ff  <= '0;
         loads_ff <= 0;
      end else if (load) begin
         held_ff  <= code;
         loads_ff <= loads_ff + 1;
      end
   end
endmodule

//--- testbench/aos_props.sv
// Port assertions for the analog output scaler
`timescale 1ns/1ps
module aos_props import aos_pkg::*; #(parameter int unsigned TICK_CYCLES = TICK_CYC) (
   input wire logic                 CLK_SYS,
   input wire logic                 RST_N,
   input wire logic                 REG_RD,
   input wire logic [PCT_W-1:0]     REG_RDATA,
   input wire logic [1:0]           OPT_FITTED,
   input wire logic [NCH*PCT_W-1:0] DAC_CODE,
   input wire logic                 DAC_LOAD
);
   logic [31:0] gap_ff;
   logic        seen_ff;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // First load only arms the period check
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         gap_ff  <= '0;
         seen_ff <= 1'b0;
      end else begin
         gap_ff  <= DAC_LOAD ? '0 : gap_ff + 32'h1;
         seen_ff <= seen_ff | DAC_LOAD;
      end
   end
   load_gap_a: assert property (seen_ff |-> DAC_LOAD == (gap_ff == TICK_CYCLES - 1)) else $error("period");
   code_hold_a: assert property (!DAC_LOAD |-> $stable(DAC_CODE)) else $error("code moved");
   rd_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == '0) else $error("stray data");
   uni_floor_a: assert property (!DAC_CODE[15]) else $error("negative");
   bip_span_a: assert property (DAC_CODE[31:16] != 16'h8000) else $error("span");
   bip_full_a: assert property (DAC_CODE[47:32] != 16'h8000) else $error("full scale");
   slot_one_a: assert property (DAC_LOAD && OPT_FITTED[0] == 1'b0 && $past(OPT_FITTED, 2) == OPT_FITTED
      && $stable(OPT_FITTED) |-> DAC_CODE[63:48] == '0) else $error("slot idle");
   slot_two_a: assert property (DAC_LOAD && OPT_FITTED[1] == 1'b0 && $past(OPT_FITTED, 2) == OPT_FITTED
      && $stable(OPT_FITTED) |-> DAC_CODE[79:64] == '0) else $error("slot idle");
endmodule
bind aos_top aos_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .OPT_FITTED(OPT_FITTED), .DAC_CODE(DAC_CODE), .DAC_LOAD(DAC_LOAD));

//--- testbench/test_analog_output_scaler.sv
// Self-checking bench for the analog output scaler
`timescale 1ns/1ps
module test_analog_output_scaler import aos_pkg::*;;
   logic                 CLK_SYS = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, rd_pend = 1'b0, DAC_LOAD;
   logic [5:0]           REG_ADDR = '0;
   logic [15:0]          REG_WDATA = '0, REG_RDATA, exp_q[$];
   logic [1:0]           OPT_FITTED = '0;
   logic [NCH*PCT_W-1:0] DAC_CODE, held;
   int                   error_cnt = 0, comparisons = 0, loads, seed = 32'h16c4, v, s, o, sd, r, ch, k, p;
   always #50 CLK_SYS = ~CLK_SYS;
   aos_top #(.TICK_CYCLES(8)) dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OPT_FITTED(OPT_FITTED), .DAC_CODE(DAC_CODE),
      .DAC_LOAD(DAC_LOAD));
   aos_dac_model dac_u (.clk(CLK_SYS), .rst_n(RST_N), .load(DAC_LOAD), .code(DAC_CODE), .held_ff(held),
      .loads_ff(loads));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One bus cycle; for a read, d is the expected answer
   task automatic bus(input logic rd, input logic wr, input int a, input int d);
      REG_RD <= rd;
      REG_WR <= wr;
      REG_ADDR <= 6'(a);
      REG_WDATA <= 16'(d);
      if (rd) exp_q.push_back(16'(d));
      @(posedge CLK_SYS);
   endtask
   function automatic int sat(input int x, input int lim);
      return x > lim ? lim : (x < -lim ? -lim : x);
   endfunction
   // Processed percent in hundredths, as the result field reports it
   function automatic int expp(input int v, s, o, sd, r, ch, f);
      int q;
      q = sat(v * s / 10000 + o, 10000);
      if (sd != 0) q = q < 0 ? -q : q;
      else if (r != 0 && q < 0) q = 0;
      if (r > 1 || (ch == 0 && r != 1) || (ch inside {1, 2} && r != 0))
         q = 0;
      if (ch > 2 && f == 0)
         q = 0;
      return q;
   endfunction
   always @(posedge CLK_SYS) begin
      if (rd_pend) cmp(REG_RDATA, exp_q.pop_front());
      rd_pend <= REG_RD;
   end
   initial begin
      repeat (8) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      @(posedge CLK_SYS);
      bus(1'b1, 1'b0, 'h01, 'h2710);
      bus(1'b1, 1'b0, 'h0b, 'h0002);
      bus(1'b1, 1'b0, 'h28, 'h0000);
      for (int i = 0; i < 24; i++) begin
         ch = i % 5;
         r = (i / 5) % 4;
         v = $random(seed) % 32768;
         s = $random(seed) % 32768;
         o = $random(seed) % 12000;
         sd = $random(seed) & 1;
         OPT_FITTED <= 2'($random(seed));
         bus(1'b0, 1'b1, ch * 8, v);
         bus(1'b0, 1'b1, ch * 8 + 1, s);
         bus(1'b0, 1'b1, ch * 8 + 2, o);
         bus(1'b0, 1'b1, ch * 8 + 3, r * 2 + sd);
         bus(1'b1, 1'b0, ch * 8 + 1, sat(s, 30000));
         bus(1'b1, 1'b0, ch * 8 + 3, r * 2 + sd);
         bus(1'b0, 1'b0, 0, 0);
         k = loads + 2;
         for (int n = 0; n < 40 && loads < k; n++) @(posedge CLK_SYS);
         if (loads < k) begin
            error_cnt++;
            report_and_stop;
         end
         p = expp(sat(v, 30000), sat(s, 30000), sat(o, 30000), sd, r, ch, OPT_FITTED[ch == 4]);
         cmp(held[ch*16 +: 16], 16'(p * 32767 / 10000));
         bus(1'b1, 1'b0, ch * 8 + 4, p);
         bus(1'b0, 1'b0, 0, 0);
      end
      // Let the last read answer land before the verdict
      repeat (2) @(posedge CLK_SYS);
      if (exp_q.size() != 0)
         error_cnt++;
      report_and_stop;
   end
endmodule
